// ==== rsel_pkg.sv ====
`default_nettype none
package rsel_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [11:0] SRC_SEL_ADDR   = 12'h000;
    localparam logic [11:0] FORCE_EN_ADDR  = 12'h004;
    localparam logic [11:0] FORCE_VAL_ADDR = 12'h008;
    localparam logic [11:0] RELAY_STS_ADDR = 12'h00c;
    localparam int          SEL_W          = 6;
    localparam int          FORCE_W        = 3;
    localparam int          FIRST_RELAY    = 0;
    localparam logic [5:0]  SEL_RESET      = 6'h02;
    localparam logic [2:0]  FORCE_RESET    = 3'h0;

    // ---------------------------------------------------------------
    // Selection codes
    // ---------------------------------------------------------------
    localparam logic [5:0] C_OFF       = 6'h00;
    localparam logic [5:0] C_ON        = 6'h01;
    localparam logic [5:0] C_READY_RUN = 6'h02;
    localparam logic [5:0] C_ENABLED   = 6'h04;
    localparam logic [5:0] C_STARTED   = 6'h05;
    localparam logic [5:0] C_MAGNET    = 6'h06;
    localparam logic [5:0] C_RUNNING   = 6'h07;
    localparam logic [5:0] C_READY_REF = 6'h08;
    localparam logic [5:0] C_AT_SETPT  = 6'h09;
    localparam logic [5:0] C_REVERSE   = 6'h0a;
    localparam logic [5:0] C_ZERO_SPD  = 6'h0b;
    localparam logic [5:0] C_ABOVE_LIM = 6'h0c;
    localparam logic [5:0] C_WARNING   = 6'h0d;
    localparam logic [5:0] C_FAULT     = 6'h0e;
    localparam logic [5:0] C_NO_FAULT  = 6'h0f;
    localparam logic [5:0] C_BRAKE     = 6'h16;
    localparam logic [5:0] C_LOC_TWO   = 6'h17;
    localparam logic [5:0] C_REMOTE    = 6'h18;
    localparam logic [5:0] C_TIMER1    = 6'h1b;
    localparam logic [5:0] C_TIMER2    = 6'h1c;
    localparam logic [5:0] C_TIMER3    = 6'h1d;
    localparam logic [5:0] C_SUPV1     = 6'h21;
    localparam logic [5:0] C_SUPV2     = 6'h22;

    // ---------------------------------------------------------------
    // Status bit positions
    // ---------------------------------------------------------------
    localparam int MS_READY_RUN = 1;
    localparam int MS_READY_REF = 2;
    localparam int MS_FAULT     = 3;
    localparam int MS_WARNING   = 7;
    localparam int MS_AT_SETPT  = 8;
    localparam int MS_REMOTE    = 9;
    localparam int D1_ENABLED   = 0;
    localparam int D1_STARTED   = 5;
    localparam int D1_RUNNING   = 6;
    localparam int D1_LOC_TWO   = 11;
    localparam int D2_MAGNET    = 1;
    localparam int D2_ABOVE_LIM = 10;
    localparam int SC_ZERO_SPD  = 0;
    localparam int SC_REVERSE   = 2;
    localparam int BR_COMMAND   = 0;
    localparam int TM_FUNC1     = 0;
    localparam int TM_FUNC2     = 1;
    localparam int TM_FUNC3     = 2;
    localparam int SV_FUNC1     = 0;
    localparam int SV_FUNC2     = 1;

    typedef struct packed {
        logic [5:0]  sel;
        logic [2:0]  force_en;
        logic [2:0]  force_val;
        logic        relay;
        logic [31:0] rdata;
        logic        slverr;
    } rsel_state_t;
endpackage : rsel_pkg
`default_nettype wire

// ==== rsel_relay_source_select.sv ====
// Functional notes
// RULE_01: Reset selection is code 2, ready-to-run
// RULE_02: Code 0 off, code 1 on
// RULE_03: Code 2 follows main status bit 1
// RULE_04: Code 4 follows drive status one bit 0
// RULE_05: Code 5 follows drive status one bit 5
// RULE_06: Code 6 follows drive status two bit 1
// RULE_07: Code 7 follows drive status one bit 6
// RULE_08: Code 8 follows main status bit 2
// RULE_09: Code 9 follows main status bit 8
// RULE_10: Code 10 follows speed status bit 2
// RULE_11: Code 11 follows speed status bit 0
// RULE_12: Code 12 follows drive status two bit 10
// RULE_13: Code 13 follows main status bit 7
// RULE_14: Code 14 follows main status bit 3
// RULE_15: Code 15 follows inverted main status bit 3
// RULE_16: Code 22 follows brake status bit 0
// RULE_17: Code 23 follows drive status one bit 11
// RULE_18: Code 24 follows main status bit 9
// RULE_19: Codes 27-29 follow timer bits 0-2
// RULE_20: Codes 33-34 follow supervision bits 0-1
// RULE_21: Force enable substitutes forced data bit
// RULE_22: Unassigned codes hold output off
// RULE_23: Output registered every clock cycle
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rsel_relay_source_select (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] main_status,
    input  wire logic [15:0] drive_status_one,
    input  wire logic [15:0] drive_status_two,
    input  wire logic [15:0] speed_status,
    input  wire logic [15:0] brake_status,
    input  wire logic [15:0] timer_status,
    input  wire logic [15:0] supervision_status,
    output logic             first_relay_output
);
    // ---------------------------------------------------------------
    // Source decode
    // ---------------------------------------------------------------
    function automatic logic src_bit(
        input logic [5:0]  s,
        input logic [15:0] ms,
        input logic [15:0] d1,
        input logic [15:0] d2,
        input logic [15:0] sc,
        input logic [15:0] br,
        input logic [15:0] tm,
        input logic [15:0] sv
    );
        logic b;
        b = 1'b0;
        case (s)
            rsel_pkg::C_OFF:       b = 1'b0;                          // RULE_02
            rsel_pkg::C_ON:        b = 1'b1;                          // RULE_02
            rsel_pkg::C_READY_RUN: b = ms[rsel_pkg::MS_READY_RUN];    // RULE_03
            rsel_pkg::C_ENABLED:   b = d1[rsel_pkg::D1_ENABLED];      // RULE_04
            rsel_pkg::C_STARTED:   b = d1[rsel_pkg::D1_STARTED];      // RULE_05
            rsel_pkg::C_MAGNET:    b = d2[rsel_pkg::D2_MAGNET];       // RULE_06
            rsel_pkg::C_RUNNING:   b = d1[rsel_pkg::D1_RUNNING];      // RULE_07
            rsel_pkg::C_READY_REF: b = ms[rsel_pkg::MS_READY_REF];    // RULE_08
            rsel_pkg::C_AT_SETPT:  b = ms[rsel_pkg::MS_AT_SETPT];     // RULE_09
            rsel_pkg::C_REVERSE:   b = sc[rsel_pkg::SC_REVERSE];      // RULE_10
            rsel_pkg::C_ZERO_SPD:  b = sc[rsel_pkg::SC_ZERO_SPD];     // RULE_11
            rsel_pkg::C_ABOVE_LIM: b = d2[rsel_pkg::D2_ABOVE_LIM];    // RULE_12
            rsel_pkg::C_WARNING:   b = ms[rsel_pkg::MS_WARNING];      // RULE_13
            rsel_pkg::C_FAULT:     b = ms[rsel_pkg::MS_FAULT];        // RULE_14
            rsel_pkg::C_NO_FAULT:  b = ~ms[rsel_pkg::MS_FAULT];       // RULE_15
            rsel_pkg::C_BRAKE:     b = br[rsel_pkg::BR_COMMAND];      // RULE_16
            rsel_pkg::C_LOC_TWO:   b = d1[rsel_pkg::D1_LOC_TWO];      // RULE_17
            rsel_pkg::C_REMOTE:    b = ms[rsel_pkg::MS_REMOTE];       // RULE_18
            rsel_pkg::C_TIMER1:    b = tm[rsel_pkg::TM_FUNC1];        // RULE_19
            rsel_pkg::C_TIMER2:    b = tm[rsel_pkg::TM_FUNC2];        // RULE_19
            rsel_pkg::C_TIMER3:    b = tm[rsel_pkg::TM_FUNC3];        // RULE_19
            rsel_pkg::C_SUPV1:     b = sv[rsel_pkg::SV_FUNC1];        // RULE_20
            rsel_pkg::C_SUPV2:     b = sv[rsel_pkg::SV_FUNC2];        // RULE_20
            // Reserved codes fail safe: relay stays dropped out
            default:               b = 1'b0;                          // RULE_22
        endcase
        return b;
    endfunction : src_bit

    rsel_pkg::rsel_state_t state_q;
    rsel_pkg::rsel_state_t state_d;
    logic                  chosen;
    logic                  setup;
    logic                  wr_acc;
    logic                  src_free;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign chosen = src_bit(state_q.sel, main_status, drive_status_one,
                            drive_status_two, speed_status, brake_status,
                            timer_status, supervision_status);
    // Force bit masks every source check below
    assign src_free = ~state_q.force_en[rsel_pkg::FIRST_RELAY];

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // Force overrides the selection, not the register value
        if (state_q.force_en[rsel_pkg::FIRST_RELAY]) begin
            state_d.relay = state_q.force_val[rsel_pkg::FIRST_RELAY]; // RULE_21
        end else begin
            state_d.relay = chosen;                                    // RULE_23
        end
        // Read data captured in setup so prdata comes from a flop
        if (setup) begin
            state_d.rdata  = 32'h0000_0000;
            state_d.slverr = 1'b0;
            if (paddr == rsel_pkg::SRC_SEL_ADDR) begin
                state_d.rdata[5:0] = state_q.sel;
            end else if (paddr == rsel_pkg::FORCE_EN_ADDR) begin
                state_d.rdata[2:0] = state_q.force_en;
            end else if (paddr == rsel_pkg::FORCE_VAL_ADDR) begin
                state_d.rdata[2:0] = state_q.force_val;
            end else if (paddr == rsel_pkg::RELAY_STS_ADDR) begin
                state_d.rdata[0] = state_q.relay;
            end else begin
                state_d.slverr = 1'b1;
            end
        end
        if (wr_acc) begin
            if (paddr == rsel_pkg::SRC_SEL_ADDR) begin
                state_d.sel = pwdata[5:0];
            end else if (paddr == rsel_pkg::FORCE_EN_ADDR) begin
                state_d.force_en = pwdata[2:0];
            end else if (paddr == rsel_pkg::FORCE_VAL_ADDR) begin
                state_d.force_val = pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.sel       <= rsel_pkg::SEL_RESET;                  // RULE_01
            state_q.force_en  <= rsel_pkg::FORCE_RESET;
            state_q.force_val <= rsel_pkg::FORCE_RESET;
            state_q.relay     <= 1'b0;
            state_q.rdata     <= 32'h0000_0000;
            state_q.slverr    <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata             = state_q.rdata;
    assign pslverr            = state_q.slverr & psel & penable;
    // Zero wait states: setup phase already prepared the answer
    assign pready             = 1'b1;
    assign first_relay_output = state_q.relay;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_out_follows_src: assert property (                                    // RULE_23
        !state_q.force_en[0] |=> first_relay_output == $past(chosen))
        else $error("relay output did not follow chosen source");
    a_force_wins: assert property (                                         // RULE_21
        state_q.force_en[0] |=> first_relay_output == $past(state_q.force_val[0]))
        else $error("forced value not applied");
    a_code_off: assert property (                                           // RULE_02
        state_q.sel == rsel_pkg::C_OFF && !state_q.force_en[0]
        |=> !first_relay_output)
        else $error("code 0 did not de-energize");
    a_code_on: assert property (                                            // RULE_02
        state_q.sel == rsel_pkg::C_ON && !state_q.force_en[0]
        |=> first_relay_output)
        else $error("code 1 did not energize");
    a_fault_inv: assert property (                                          // RULE_15
        state_q.sel == rsel_pkg::C_NO_FAULT && !state_q.force_en[0]
        |=> first_relay_output != $past(main_status[3]))
        else $error("inverted fault source wrong");
    a_fault_dir: assert property (                                          // RULE_14
        state_q.sel == rsel_pkg::C_FAULT && !state_q.force_en[0]
        |=> first_relay_output == $past(main_status[3]))
        else $error("fault source wrong");
    a_ready_run: assert property (                                          // RULE_03
        state_q.sel == rsel_pkg::C_READY_RUN && !state_q.force_en[0]
        |=> first_relay_output == $past(main_status[1]))
        else $error("ready-to-run source wrong");
    a_reserved_off: assert property (                                       // RULE_22
        (state_q.sel == 6'h03 || state_q.sel == 6'h10 || state_q.sel == 6'h1e)
        && !state_q.force_en[0] |=> !first_relay_output)
        else $error("reserved code energized relay");
    a_sel_write: assert property (                                          // RULE_01
        wr_acc && paddr == rsel_pkg::SRC_SEL_ADDR
        |=> state_q.sel == $past(pwdata[5:0]))
        else $error("selection write lost");
    a_sel_hold: assert property (                                           // RULE_01
        !(wr_acc && paddr == rsel_pkg::SRC_SEL_ADDR) |=> $stable(state_q.sel))
        else $error("selection changed without write");

    // ---------------------------------------------------------------
    // Main status word sources
    // ---------------------------------------------------------------
    // Relay is a flop, so each source is compared one edge back
    a_src_ready_ref: assert property ( // RULE_08
        src_free && state_q.sel == rsel_pkg::C_READY_REF
        |=> first_relay_output == $past(main_status[rsel_pkg::MS_READY_REF]))
        else $error("reference-ready source wrong");

    a_src_setpoint: assert property ( // RULE_09
        src_free && state_q.sel == rsel_pkg::C_AT_SETPT
        |=> first_relay_output == $past(main_status[rsel_pkg::MS_AT_SETPT]))
        else $error("at-setpoint source wrong");

    a_src_warning: assert property ( // RULE_13
        src_free && state_q.sel == rsel_pkg::C_WARNING
        |=> first_relay_output == $past(main_status[rsel_pkg::MS_WARNING]))
        else $error("warning source wrong");

    a_src_remote: assert property ( // RULE_18
        src_free && state_q.sel == rsel_pkg::C_REMOTE
        |=> first_relay_output == $past(main_status[rsel_pkg::MS_REMOTE]))
        else $error("remote-control source wrong");

    // ---------------------------------------------------------------
    // Drive status word sources
    // ---------------------------------------------------------------
    // A wrong word would still pass the constant codes
    a_src_enabled: assert property ( // RULE_04
        src_free && state_q.sel == rsel_pkg::C_ENABLED
        |=> first_relay_output == $past(drive_status_one[rsel_pkg::D1_ENABLED]))
        else $error("enabled source wrong");

    a_src_started: assert property ( // RULE_05
        src_free && state_q.sel == rsel_pkg::C_STARTED
        |=> first_relay_output == $past(drive_status_one[rsel_pkg::D1_STARTED]))
        else $error("started source wrong");

    a_src_running: assert property ( // RULE_07
        src_free && state_q.sel == rsel_pkg::C_RUNNING
        |=> first_relay_output == $past(drive_status_one[rsel_pkg::D1_RUNNING]))
        else $error("running source wrong");

    a_src_loc_two: assert property ( // RULE_17
        src_free && state_q.sel == rsel_pkg::C_LOC_TWO
        |=> first_relay_output == $past(drive_status_one[rsel_pkg::D1_LOC_TWO]))
        else $error("second location source wrong");

    a_src_magnet: assert property ( // RULE_06
        src_free && state_q.sel == rsel_pkg::C_MAGNET
        |=> first_relay_output == $past(drive_status_two[rsel_pkg::D2_MAGNET]))
        else $error("magnetized source wrong");

    a_src_above_lim: assert property ( // RULE_12
        src_free && state_q.sel == rsel_pkg::C_ABOVE_LIM
        |=> first_relay_output == $past(drive_status_two[rsel_pkg::D2_ABOVE_LIM]))
        else $error("above-limit source wrong");

    // ---------------------------------------------------------------
    // Speed and brake sources
    // ---------------------------------------------------------------
    // Brake relay is safety related: no extra latency allowed
    a_src_reverse: assert property ( // RULE_10
        src_free && state_q.sel == rsel_pkg::C_REVERSE
        |=> first_relay_output == $past(speed_status[rsel_pkg::SC_REVERSE]))
        else $error("reverse source wrong");

    a_src_zero_speed: assert property ( // RULE_11
        src_free && state_q.sel == rsel_pkg::C_ZERO_SPD
        |=> first_relay_output == $past(speed_status[rsel_pkg::SC_ZERO_SPD]))
        else $error("zero-speed source wrong");

    a_src_brake: assert property ( // RULE_16
        src_free && state_q.sel == rsel_pkg::C_BRAKE
        |=> first_relay_output == $past(brake_status[rsel_pkg::BR_COMMAND]))
        else $error("brake source wrong");

    // ---------------------------------------------------------------
    // Timer and supervision sources
    // ---------------------------------------------------------------
    a_src_timer_one: assert property ( // RULE_19
        src_free && state_q.sel == rsel_pkg::C_TIMER1
        |=> first_relay_output == $past(timer_status[rsel_pkg::TM_FUNC1]))
        else $error("timer one source wrong");

    a_src_timer_two: assert property ( // RULE_19
        src_free && state_q.sel == rsel_pkg::C_TIMER2
        |=> first_relay_output == $past(timer_status[rsel_pkg::TM_FUNC2]))
        else $error("timer two source wrong");

    a_src_timer_three: assert property ( // RULE_19
        src_free && state_q.sel == rsel_pkg::C_TIMER3
        |=> first_relay_output == $past(timer_status[rsel_pkg::TM_FUNC3]))
        else $error("timer three source wrong");

    a_src_supv_one: assert property ( // RULE_20
        src_free && state_q.sel == rsel_pkg::C_SUPV1
        |=> first_relay_output == $past(supervision_status[rsel_pkg::SV_FUNC1]))
        else $error("supervision one source wrong");

    a_src_supv_two: assert property ( // RULE_20
        src_free && state_q.sel == rsel_pkg::C_SUPV2
        |=> first_relay_output == $past(supervision_status[rsel_pkg::SV_FUNC2]))
        else $error("supervision two source wrong");

    // Codes past the last source fail safe too
    a_reserved_high: assert property ( // RULE_22
        src_free && state_q.sel > rsel_pkg::C_SUPV2
        |=> !first_relay_output)
        else $error("high reserved code energized relay");

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    // Read data is built in setup and shown on the access edge
    a_rd_select: assert property ( // RULE_01
        setup && paddr == rsel_pkg::SRC_SEL_ADDR
        |=> prdata == {26'h0, $past(state_q.sel)})
        else $error("selection readback wrong");

    a_rd_force_en: assert property ( // RULE_21
        setup && paddr == rsel_pkg::FORCE_EN_ADDR
        |=> prdata == {29'h0, $past(state_q.force_en)})
        else $error("force enable readback wrong");

    a_rd_force_val: assert property ( // RULE_21
        setup && paddr == rsel_pkg::FORCE_VAL_ADDR
        |=> prdata == {29'h0, $past(state_q.force_val)})
        else $error("forced value readback wrong");

    a_rd_status: assert property ( // RULE_23
        setup && paddr == rsel_pkg::RELAY_STS_ADDR
        |=> prdata == {31'h0, $past(first_relay_output)})
        else $error("relay status readback wrong");

    a_force_en_write: assert property ( // RULE_21
        wr_acc && paddr == rsel_pkg::FORCE_EN_ADDR
        |=> state_q.force_en == $past(pwdata[2:0]))
        else $error("force enable write lost");

    a_force_val_write: assert property ( // RULE_21
        wr_acc && paddr == rsel_pkg::FORCE_VAL_ADDR
        |=> state_q.force_val == $past(pwdata[2:0]))
        else $error("forced value write lost");

    a_force_hold: assert property ( // RULE_21
        !(wr_acc && paddr == rsel_pkg::FORCE_EN_ADDR) |=> $stable(state_q.force_en))
        else $error("force enable changed without write");

    a_force_val_hold: assert property ( // RULE_21
        !(wr_acc && paddr == rsel_pkg::FORCE_VAL_ADDR) |=> $stable(state_q.force_val))
        else $error("forced value changed without write");

    // Reset checks run with the default disable switched off
    a_sel_reset: assert property ( // RULE_01
        disable iff (1'b0) !presetn |=> state_q.sel == rsel_pkg::SEL_RESET)
        else $error("selection not at reset code");

    a_relay_reset: assert property ( // RULE_01
        disable iff (1'b0) !presetn |=> !first_relay_output)
        else $error("relay energized after reset");

    c_force_used: cover property (state_q.force_en[0] ##1 first_relay_output);
    c_sel_write:  cover property (wr_acc && paddr == rsel_pkg::SRC_SEL_ADDR);
    c_bad_addr:   cover property (pslverr);
    c_supv_on:    cover property (state_q.sel == rsel_pkg::C_SUPV2 ##1 first_relay_output);
    c_no_fault:   cover property (state_q.sel == rsel_pkg::C_NO_FAULT ##1 !first_relay_output);
endmodule : rsel_relay_source_select
`default_nettype wire

// ==== rsel_status_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------
// Status words feeding the relay selector
// -------------------------------------------
module rsel_status_src (
    input  wire logic             pclk,
    input  wire logic [6:0][15:0] nxt,
    output logic      [6:0][15:0] words
);
    // Registered, so words only move just after an edge
    always_ff @(posedge pclk) begin
        words <= nxt;
    end
endmodule : rsel_status_src
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed { int c; logic v; } rsel_note_t;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             relay;
    logic [6:0][15:0] nxt = '0;
    logic [6:0][15:0] w;
    logic [2:0]       fen = '0;
    logic [2:0]       fval = '0;
    logic [31:0]      rd;
    logic             er;
    int               n_errors = 0;
    int               n_checks = 0;
    int               cyc = 0;
    rsel_note_t       q[$];
    // Entry: code, word (7 constant, 8 inverted main word), bit
    logic [15:0] tbl [32] = '{16'h0070, 16'h0171, 16'h0201, 16'h0410, 16'h0515,
        16'h0621, 16'h0716, 16'h0802, 16'h0908, 16'h0a32, 16'h0b30,
        16'h0c2a, 16'h0d07, 16'h0e03, 16'h0f83, 16'h1640, 16'h171b,
        16'h1809, 16'h1b50, 16'h1c51, 16'h1d52, 16'h2160, 16'h2261,
        16'h0370, 16'h1070, 16'h1570, 16'h1970, 16'h1a70, 16'h1e70,
        16'h2070, 16'h2370, 16'h3f70};

    rsel_status_src rsel_status_src_i (.pclk(pclk), .nxt(nxt), .words(w));
    rsel_relay_source_select rsel_relay_source_select_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_status(w[0]), .drive_status_one(w[1]), .drive_status_two(w[2]),
        .speed_status(w[3]), .brake_status(w[4]), .timer_status(w[5]),
        .supervision_status(w[6]), .first_relay_output(relay));

    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    // -------------------------------------------
    // Helpers
    // -------------------------------------------
    task automatic summarize;
        n_errors += q.size();
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic calc(input logic [15:0] e, input logic [6:0][15:0] s);
        if (fen[0]) return fval[0];
        if (e[7:4] == 4'h7) return e[0];
        if (e[7:4] == 4'h8) return ~s[0][e[3:0]];
        return s[e[6:4]][e[3:0]];
    endfunction : calc

    // No wait count assumed; only the bound cuts a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Target bit forced to b so both levels are seen per source code
    task automatic drive(input logic [15:0] e, input logic b);
        logic [6:0][15:0] s;
        for (int i = 0; i < 7; i++) s[i] = 16'($urandom);
        if (e[7:4] != 4'h7) s[e[6:4]][e[3:0]] = b;
        @(posedge pclk);
        nxt <= s;
        q.push_back('{cyc + 3, calc(e, s)});
    endtask : drive

    task automatic burst(input logic [15:0] e);
        for (int k = 0; k < 4; k++) drive(e, k[0]);
        repeat (4) @(posedge pclk);
    endtask : burst

    always @(negedge pclk) begin
        while (q.size() > 0 && q[0].c <= cyc) begin
            chk("relay", {31'h0, relay}, {31'h0, q[0].v});
            void'(q.pop_front());
        end
    end

    // -------------------------------------------
    // Sequence
    // -------------------------------------------
    initial begin
        #50000;
        n_errors++;
        summarize();
    end

    initial begin
        void'($urandom(62147));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        burst(tbl[2]);
        apb(1'b0, rsel_pkg::SRC_SEL_ADDR, '0);
        chk("select reset", rd, 32'h2);
        apb(1'b0, rsel_pkg::FORCE_EN_ADDR, '0);
        chk("force enable reset", rd, '0);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk("unmapped error", {31'h0, er}, 32'h1);
        foreach (tbl[i]) begin
            apb(1'b1, rsel_pkg::SRC_SEL_ADDR, {26'h3ffffff, tbl[i][13:8]});
            apb(1'b0, rsel_pkg::SRC_SEL_ADDR, '0);
            chk("select", rd, {26'h0, tbl[i][13:8]});
            burst(tbl[i]);
        end
        apb(1'b1, rsel_pkg::SRC_SEL_ADDR, 32'h1);
        apb(1'b1, rsel_pkg::FORCE_EN_ADDR, 32'h7);
        fen = 3'h7;
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, rsel_pkg::FORCE_VAL_ADDR, 32'(v));
            fval = 3'(v);
            burst(tbl[1]);
            apb(1'b0, rsel_pkg::RELAY_STS_ADDR, '0);
            chk("relay status", rd, 32'(v));
        end
        apb(1'b0, rsel_pkg::SRC_SEL_ADDR, '0);
        chk("select under force", rd, 32'h1);
        apb(1'b1, rsel_pkg::FORCE_EN_ADDR, 32'h0);
        fen = 3'h0;
        apb(1'b1, rsel_pkg::SRC_SEL_ADDR, 32'h0);
        burst(tbl[0]);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
